/* inc/cbr_pkg.sv */
package cbr_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [31:0] refresh_row_counter_addr = 32'hc00001f0;
  localparam logic [31:0] bus_control_addr = 32'hc00001f4;
  localparam logic [31:0] bus_status_addr = 32'hc00001f8;
  localparam logic [31:0] cycle_request_addr = 32'hc00001fc;
  localparam logic [15:0] refresh_row_reset = 16'h0000;
  localparam int ctl_stretch_bit = 0;
  localparam int ctl_req_lsb = 1;
  localparam int req_refresh_bit = 0;
  localparam int req_write_bit = 1;
  localparam int req_rmw_bit = 2;
  // ****************************************************************
  // bus field layout and codes
  // ****************************************************************
  localparam logic [3:0] refresh_status_code = 4'h3;
  localparam logic [11:0] refresh_mid_zero = 12'h000;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
  // ****************************************************************
  // timing: one local quarter-period is one enable pulse
  // ****************************************************************
  localparam int clk_period_ns = 8;
  localparam int quarter_ns = 16;
  localparam int quarter_cycles = (quarter_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] stretch_quarters = 4'h2;
  localparam logic [3:0] ras_low_quarters = 4'h4;
  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_grant = 7'b0000010,
    st_cas_first = 7'b0000100,
    st_ras_low = 7'b0001000,
    st_ras_first = 7'b0010000,
    st_we_low = 7'b0100000,
    st_release = 7'b1000000
  } cyc_state_t;
endpackage : cbr_pkg

/* logic/cbr_refresh_and_bus_grant.sv */
`timescale 1ns/1ps
module cbr_refresh_and_bus_grant (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bus_grant_in_n,
  output logic [31:0] local_addr_data_o,
  output logic local_addr_data_oe_n,
  output logic ras_n,
  output logic [3:0] column_strobes_n,
  output logic we_n,
  output logic bus_req_code0,
  output logic bus_req_code1,
  output logic local_clock_phase1,
  output logic local_clock_phase2
);
  // ****************************************************************
  // quarter-period divider and local clock phases
  // ****************************************************************
  logic [3:0] qdiv_ff;
  logic qtick;
  logic [1:0] quarter_ff;
  assign qtick = (qdiv_ff == 4'(cbr_pkg::quarter_cycles - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qdiv_ff <= 4'h0;
    end else begin
      qdiv_ff <= qtick ? 4'h0 : qdiv_ff + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quarter_ff <= 2'h0;
    end else if (qtick) begin
      quarter_ff <= quarter_ff + 2'h1;
    end
  end
  // phase1 high in quarters 0-1, phase2 high in quarters 1-2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_clock_phase1 <= 1'b0;
      local_clock_phase2 <= 1'b0;
    end else if (qtick) begin
      local_clock_phase1 <= (quarter_ff == 2'h3) || (quarter_ff == 2'h0);
      local_clock_phase2 <= (quarter_ff == 2'h0) || (quarter_ff == 2'h1);
    end
  end
  logic q1_start, phase2_rise;
  assign q1_start = qtick && (quarter_ff == 2'h3);
  assign phase2_rise = qtick && (quarter_ff == 2'h0);
  // ****************************************************************
  // grant pin synchroniser
  // ****************************************************************
  logic [2:0] grant_sync_ff;
  logic grant_low_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_sync_ff <= 3'b111;
      grant_low_ff <= 1'b0;
    end else begin
      grant_sync_ff <= {grant_sync_ff[1:0], bus_grant_in_n};
      if (grant_sync_ff[1] == grant_sync_ff[2]) grant_low_ff <= !grant_sync_ff[2];
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] refresh_row_counter_ff;
  logic stretch_en_ff;
  logic [1:0] req_code_cfg_ff;
  logic [2:0] pend_ff;
  logic owned_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic do_write, refresh_done;
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 32'h0;
      wdata_ff <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end
  logic wr_known;
  assign wr_known = (awaddr_ff == cbr_pkg::refresh_row_counter_addr) ||
                    (awaddr_ff == cbr_pkg::bus_control_addr) ||
                    (awaddr_ff == cbr_pkg::cycle_request_addr);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cbr_pkg::axi_okay;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known ? cbr_pkg::axi_okay : cbr_pkg::axi_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stretch_en_ff <= 1'b0;
      req_code_cfg_ff <= 2'h3;
    end else if (do_write && awaddr_ff == cbr_pkg::bus_control_addr && s_axi_wstrb[0]) begin
      stretch_en_ff <= wdata_ff[cbr_pkg::ctl_stretch_bit];
      req_code_cfg_ff <= wdata_ff[cbr_pkg::ctl_req_lsb +: 2];
    end
  end
  // counter advances after each refresh; software write overrides
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_row_counter_ff <= cbr_pkg::refresh_row_reset;
    end else if (do_write && awaddr_ff == cbr_pkg::refresh_row_counter_addr) begin
      if (s_axi_wstrb[0]) refresh_row_counter_ff[7:0] <= wdata_ff[7:0];
      if (s_axi_wstrb[1]) refresh_row_counter_ff[15:8] <= wdata_ff[15:8];
    end else if (refresh_done) begin
      refresh_row_counter_ff <= refresh_row_counter_ff + 16'h1;
    end
  end
  // ****************************************************************
  // read channel
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= cbr_pkg::axi_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cbr_pkg::axi_okay;
      case (s_axi_araddr)
        cbr_pkg::refresh_row_counter_addr: s_axi_rdata <= {16'h0, refresh_row_counter_ff};
        cbr_pkg::bus_control_addr: s_axi_rdata <= {29'h0, req_code_cfg_ff, stretch_en_ff};
        cbr_pkg::bus_status_addr: s_axi_rdata <= {28'h0, owned_ff, pend_ff};
        cbr_pkg::cycle_request_addr: s_axi_rdata <= {29'h0, pend_ff};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= cbr_pkg::axi_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ****************************************************************
  // request codes
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_req_code0 <= 1'b1;
      bus_req_code1 <= 1'b1;
    end else if (phase2_rise) begin
      bus_req_code0 <= (pend_ff != 3'h0) ? req_code_cfg_ff[0] : 1'b1;
      bus_req_code1 <= (pend_ff != 3'h0) ? req_code_cfg_ff[1] : 1'b1;
    end
  end
  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  cbr_pkg::cyc_state_t state_ff;
  logic [3:0] qcnt_ff;
  logic [2:0] kind_ff;
  logic set_done;
  assign refresh_done = set_done && kind_ff[cbr_pkg::req_refresh_bit];
  // set wins over the clear when the cycle that ends is re-requested
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= 3'h0;
    end else begin
      pend_ff <= (pend_ff & ~(set_done ? kind_ff : 3'h0)) |
                 ((do_write && awaddr_ff == cbr_pkg::cycle_request_addr) ? wdata_ff[2:0] : 3'h0);
    end
  end
  logic [3:0] ras_len;
  assign ras_len = cbr_pkg::ras_low_quarters +
                   ((stretch_en_ff && kind_ff[cbr_pkg::req_rmw_bit]) ? cbr_pkg::stretch_quarters : 4'h0);
  assign set_done = qtick && (state_ff == cbr_pkg::st_release);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= cbr_pkg::st_idle;
      qcnt_ff <= 4'h0;
      kind_ff <= 3'h0;
      owned_ff <= 1'b0;
      ras_n <= 1'b1;
      column_strobes_n <= 4'hf;
      we_n <= 1'b1;
      local_addr_data_o <= 32'h0;
      local_addr_data_oe_n <= 1'b1;
    end else if (qtick) begin
      case (state_ff)
        cbr_pkg::st_idle: begin
          if (pend_ff != 3'h0) begin
            kind_ff <= pend_ff[0] ? 3'h1 : (pend_ff[1] ? 3'h2 : 3'h4);
            state_ff <= cbr_pkg::st_grant;
          end
        end
        cbr_pkg::st_grant: begin
          if (q1_start && grant_low_ff) begin
            owned_ff <= 1'b1;
            local_addr_data_oe_n <= 1'b0;
            if (kind_ff[cbr_pkg::req_refresh_bit]) begin
              local_addr_data_o <= {refresh_row_counter_ff,
                                    cbr_pkg::refresh_mid_zero,
                                    cbr_pkg::refresh_status_code};
              column_strobes_n <= 4'h0;
              state_ff <= cbr_pkg::st_cas_first;
            end else begin
              local_addr_data_o <= {refresh_row_counter_ff, 16'h0};
              ras_n <= 1'b0;
              qcnt_ff <= 4'h0;
              state_ff <= cbr_pkg::st_ras_first;
            end
          end
        end
        cbr_pkg::st_cas_first: begin
          ras_n <= 1'b0;
          qcnt_ff <= 4'h0;
          state_ff <= cbr_pkg::st_ras_low;
        end
        cbr_pkg::st_ras_first: begin
          qcnt_ff <= qcnt_ff + 4'h1;
          if (kind_ff[cbr_pkg::req_write_bit]) begin
            we_n <= 1'b0;
            state_ff <= cbr_pkg::st_we_low;
          end else begin
            column_strobes_n <= 4'h0;
            state_ff <= cbr_pkg::st_ras_low;
          end
        end
        cbr_pkg::st_we_low: begin
          qcnt_ff <= qcnt_ff + 4'h1;
          column_strobes_n <= 4'h0;
          state_ff <= cbr_pkg::st_ras_low;
        end
        cbr_pkg::st_ras_low: begin
          qcnt_ff <= qcnt_ff + 4'h1;
          if (qcnt_ff + 4'h1 >= ras_len) begin
            ras_n <= 1'b1;
            state_ff <= cbr_pkg::st_release;
          end
        end
        cbr_pkg::st_release: begin
          column_strobes_n <= 4'hf;
          we_n <= 1'b1;
          local_addr_data_oe_n <= 1'b1;
          owned_ff <= 1'b0;
          state_ff <= cbr_pkg::st_idle;
        end
        default: state_ff <= cbr_pkg::st_idle;
      endcase
    end
  end
endmodule : cbr_refresh_and_bus_grant

/* testbench/cbr_monitor.sv */
`timescale 1ns/1ps
module cbr_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_grant_in_n,
  input wire logic [31:0] local_addr_data_o,
  input wire logic local_addr_data_oe_n,
  input wire logic ras_n,
  input wire logic [3:0] column_strobes_n,
  input wire logic we_n,
  input wire logic bus_req_code0,
  input wire logic bus_req_code1,
  input wire logic local_clock_phase2
);
  logic [4:0] low_ff;
  // counts sampled cycles of row strobe low
  always_ff @(posedge aclk) begin
    if (!aresetn || ras_n) low_ff <= 5'h00;
    else low_ff <= low_ff + 5'h01;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  refresh_field_a:
    assert property ($fell(local_addr_data_oe_n) && column_strobes_n == 4'h0
      |-> local_addr_data_o[15:0] == 16'h0003) else $error("refresh low field wrong");
  cbr_order_a:
    assert property ($fell(ras_n) && column_strobes_n == 4'h0 |-> $past(column_strobes_n) == 4'h0)
      else $error("row strobe fell with column strobes");
  ras_release_a:
    assert property ($rose(ras_n) && column_strobes_n == 4'h0 |-> ##[1:3] column_strobes_n == 4'hf)
      else $error("column strobes not released after row");
  we_first_a:
    assert property ($fell(we_n) |-> column_strobes_n == 4'hf ##[1:3] column_strobes_n == 4'h0)
      else $error("write strobe not ahead of column strobe");
  ras_width_a:
    assert property ($rose(ras_n) |-> low_ff == 5'h08 || low_ff == 5'h0c)
      else $error("row strobe low time wrong");
  req_edge_a:
    assert property ($changed({bus_req_code1, bus_req_code0}) |-> $rose(local_clock_phase2))
      else $error("request code changed off phase two rise");
  grant_own_a:
    assert property ($fell(local_addr_data_oe_n) |-> $past(bus_grant_in_n, 3) == 1'b0)
      else $error("bus taken without grant");
  strobe_own_a:
    assert property (!ras_n || column_strobes_n != 4'hf |-> !local_addr_data_oe_n)
      else $error("strobes active without bus");
  refresh_c: cover property ($fell(local_addr_data_oe_n) && column_strobes_n == 4'h0);
  write_c: cover property ($fell(we_n));
  stretch_c: cover property ($rose(ras_n) && low_ff == 5'h0c);
endmodule : cbr_monitor
bind cbr_refresh_and_bus_grant cbr_monitor mon (.aclk(aclk), .aresetn(aresetn),
  .bus_grant_in_n(bus_grant_in_n), .local_addr_data_o(local_addr_data_o),
  .local_addr_data_oe_n(local_addr_data_oe_n), .ras_n(ras_n), .we_n(we_n),
  .column_strobes_n(column_strobes_n), .bus_req_code0(bus_req_code0),
  .bus_req_code1(bus_req_code1), .local_clock_phase2(local_clock_phase2));

/* testbench/arbiter_model.sv */
`timescale 1ns/1ps
module arbiter_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_req_code0,
  input wire logic bus_req_code1,
  input wire logic deny,
  output logic bus_grant_in_n
);
  // grant while a request code is shown, unless the bench withholds it
  always_ff @(posedge aclk) begin
    if (!aresetn) bus_grant_in_n <= 1'b1;
    else bus_grant_in_n <= deny || {bus_req_code1, bus_req_code0} == 2'h3;
  end
endmodule : arbiter_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, deny = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, local_addr_data, rv;
  logic awready, wready, bvalid, arready, rvalid, gnt_n, oe_n, ras_n, we_n, c0, c1, ph1, ph2;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] cas_n;
  int fail_count = 0, n_tests = 0, cyc;
  cbr_refresh_and_bus_grant dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_grant_in_n(gnt_n), .local_addr_data_o(local_addr_data),
    .local_addr_data_oe_n(oe_n), .ras_n(ras_n), .column_strobes_n(cas_n), .we_n(we_n),
    .bus_req_code0(c0), .bus_req_code1(c1), .local_clock_phase1(ph1),
    .local_clock_phase2(ph2));
  arbiter_model arb (.aclk(aclk), .aresetn(aresetn), .bus_req_code0(c0), .bus_req_code1(c1),
    .deny(deny), .bus_grant_in_n(gnt_n));
  initial begin
    forever #4 aclk = ~aclk;
  end
  // ********
  // tasks
  // ********
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tmo();
    chk("wait bound", 32'h0, 32'h1);
    stop_test();
  endtask : tmo
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (cyc = 0; cyc < 50 && bvalid !== 1'b1; cyc++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    rs = bresp;
    if (cyc == 50) tmo();
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (cyc = 0; cyc < 50 && rvalid !== 1'b1; cyc++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    rs = rresp;
    rv = rdata;
    if (cyc == 50) tmo();
  endtask : rd
  // waits for row strobe (0), bus enable (1) or write strobe (2) to reach v
  task automatic wait_pin(input int s, input logic v);
    cyc = 0;
    do begin
      @(posedge aclk);
      cyc++;
      if (cyc > 300) tmo();
    end while ((s == 0 ? ras_n : s == 1 ? oe_n : we_n) !== v);
  endtask : wait_pin
  task automatic t_regs();
    rd(cbr_pkg::refresh_row_counter_addr);
    chk("row reset", rv, 32'h0);
    rd(cbr_pkg::bus_control_addr);
    chk("control reset", rv, 32'h6);
    rd(32'hc0000200);
    chk("unmapped read", {rv[29:0], rs}, {30'h0, cbr_pkg::axi_slverr});
    wr(32'hc0000200, 32'h1);
    chk("unmapped write", rs, cbr_pkg::axi_slverr);
    $display("register test done");
  endtask : t_regs
  task automatic t_phases();
    int hi1 = 0;
    int hi2 = 0;
    int both = 0;
    repeat (8) begin
      @(posedge aclk);
      hi1 += ph1;
      hi2 += ph2;
      both += ph1 & ph2;
    end
    chk("phase1 high cycles", hi1, 32'h4);
    chk("phase2 high cycles", hi2, 32'h4);
    chk("phase overlap cycles", both, 32'h2);
    chk("idle request code", {c1, c0}, 32'h3);
    $display("phase test done");
  endtask : t_phases
  task automatic t_refresh();
    wr(cbr_pkg::bus_control_addr, 32'h2);
    wr(cbr_pkg::refresh_row_counter_addr, 32'h1234);
    wr(cbr_pkg::cycle_request_addr, 32'h1);
    wait_pin(1, 1'b0);
    chk("refresh bus", local_addr_data, 32'h12340003);
    chk("strobes", {ras_n, cas_n}, 32'h10);
    wait_pin(0, 1'b0);
    wait_pin(0, 1'b1);
    chk("row low", cyc, 32'h8);
    wait_pin(1, 1'b1);
    rd(cbr_pkg::refresh_row_counter_addr);
    chk("row next", rv, 32'h1235);
    $display("refresh test done");
  endtask : t_refresh
  task automatic t_write();
    wr(cbr_pkg::cycle_request_addr, 32'h2);
    wait_pin(2, 1'b0);
    chk("strobes at write", {ras_n, cas_n}, 32'hf);
    wait_pin(1, 1'b1);
    $display("write test done");
  endtask : t_write
  task automatic t_stretch();
    wr(cbr_pkg::bus_control_addr, 32'h3);
    wr(cbr_pkg::cycle_request_addr, 32'h4);
    wait_pin(0, 1'b0);
    wait_pin(0, 1'b1);
    chk("stretched row low", cyc, 32'hc);
    wait_pin(1, 1'b1);
    $display("stretch test done");
  endtask : t_stretch
  task automatic t_deny();
    deny <= 1'b1;
    wr(cbr_pkg::bus_control_addr, 32'h2);
    wr(cbr_pkg::cycle_request_addr, 32'h1);
    repeat (40) @(posedge aclk);
    chk("bus held off", oe_n, 32'h1);
    rd(cbr_pkg::bus_status_addr);
    chk("pending not owned", rv[3:0], 32'h1);
    chk("pending request code", {c1, c0}, 32'h1);
    deny <= 1'b0;
    wait_pin(1, 1'b0);
    chk("refresh row", local_addr_data[31:16], 32'h1235);
    wait_pin(1, 1'b1);
    $display("grant test done");
  endtask : t_deny
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_phases();
    t_refresh();
    t_write();
    t_stretch();
    t_deny();
    stop_test();
  end
endmodule : testbench
